// [synth_serial_config_modes.sv]
// serial configuration port, mode decode and frame-pulse generator
// assumes SCK toggles only while CS_N is low, and CS_N stays high
// for at least four CLK_SYS cycles between frames
`timescale 1ns/1ns
`default_nettype none
module synth_serial_config_modes
  import synth_cfg_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SDI,
  input wire logic PULSE_REQUEST_PIN,
  output logic SECOND_RF_OUT,
  output logic LOW_POWER_HOLD,
  output logic DETERMINISTIC_PHASE_MODE,
  output logic FRAME_PULSE_MODE,
  output logic VCO_CAL_TRIGGER,
  output logic READ_VALID,
  output logic [15:0] READ_DATA,
  output logic [23:0] DELAY_WEIGHT_FIELDS,
  output logic [2:0] INTERPOLATOR_PRESCALER
);

  // ***************
  // link side, clocked by SCK
  // ***************
  logic [23:0] shift_ff, nxt_shift;
  logic [4:0] bit_cnt_ff, nxt_bit_cnt;
  logic frame_ok_ff, nxt_frame_ok;

  // shift in msb first; count saturates so long frames keep last 24 bits
  always_comb begin
    nxt_shift = {shift_ff[FRAME_BITS-2:0], SDI};
    nxt_bit_cnt = (bit_cnt_ff == FRAME_LEN) ? bit_cnt_ff : bit_cnt_ff + 5'h01;
    if (bit_cnt_ff == LAST_BIT) begin
      nxt_frame_ok = 1'b1;
    end else if (bit_cnt_ff == FIRST_BIT) begin
      nxt_frame_ok = 1'b0;
    end else begin
      nxt_frame_ok = frame_ok_ff;
    end
  end

  // the serial clock stops between frames, so chip select clears the count
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      bit_cnt_ff <= FIRST_BIT;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  // no SCK edge exists in reset, hence the asynchronous clear here
  always_ff @(posedge SCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shift_ff <= 24'h000000;
      frame_ok_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      frame_ok_ff <= nxt_frame_ok;
    end
  end

  // ***************
  // crossings into the system clock
  // ***************
  logic cs_sync;
  logic req_sync;

  sync_2ff #(.RST_VAL(1'b1)) cs_sync_u (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .d(CS_N),
    .q(cs_sync)
  );

  // the two stages stand for the interpolator and output clock resampling
  sync_2ff #(.RST_VAL(1'b0)) req_sync_u (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .d(PULSE_REQUEST_PIN),
    .q(req_sync)
  );

  // ***************
  // frame commit
  // ***************
  mem_port_if mport ();

  cfg_reg_mem mem_u (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .port(mport.mem)
  );

  logic cs_prev_ff, we_ff, re_ff, re_d1_ff, clr_ff, cal_ff;
  logic [6:0] addr_ff, nxt_addr, f_addr;
  logic [15:0] wdata_ff, mode_ff, fpc_ff, fpd_ff, dlo_ff, dhi_ff;
  logic nxt_we, nxt_re, nxt_cal, cs_rise, take, wr, hold_rst;
  logic [15:0] nxt_wdata, nxt_mode, nxt_fpc, nxt_fpd, nxt_dlo, nxt_dhi, f_data;

  // shift_ff and frame_ok_ff are static once CS_N is high, so they are
  // sampled only after chip select has passed the synchroniser
  assign cs_rise = cs_sync && !cs_prev_ff;
  assign take = cs_rise && frame_ok_ff;
  assign f_addr = shift_ff[ADDR_MSB:ADDR_LSB];
  assign f_data = shift_ff[DATA_MSB:0];
  assign hold_rst = mode_ff[POS_SOFT_RESET] && !mode_ff[POS_POWER_DOWN];
  assign wr = take && shift_ff[RW_POS] == RW_WRITE && !hold_rst;

  function automatic logic [15:0] shadow(input logic [15:0] cur, input logic [6:0] a,
                                         input logic [15:0] rv);
    if (hold_rst) begin
      shadow = rv;
    end else if (wr && f_addr == a) begin
      shadow = f_data;
    end else begin
      shadow = cur;
    end
  endfunction

  // decode a completed frame into a write, a read or nothing
  always_comb begin
    nxt_we = wr;
    nxt_re = take && shift_ff[RW_POS] != RW_WRITE;
    nxt_addr = take ? f_addr : addr_ff;
    nxt_wdata = take ? f_data : wdata_ff;
    nxt_cal = wr && f_addr == ADDR_MODE && f_data[POS_CAL_TRIG];
    nxt_mode = shadow(mode_ff, ADDR_MODE, RST_MODE);
    nxt_fpc = shadow(fpc_ff, ADDR_FP_CTRL, RST_FP_CTRL);
    nxt_fpd = shadow(fpd_ff, ADDR_FP_DIV, RST_FP_DIV);
    nxt_dlo = shadow(dlo_ff, ADDR_DLY_LO, RST_DLY_LO);
    nxt_dhi = shadow(dhi_ff, ADDR_DLY_HI, RST_DLY_HI);
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cs_prev_ff <= 1'b1;
      we_ff <= 1'b0;
      re_ff <= 1'b0;
      re_d1_ff <= 1'b0;
      clr_ff <= 1'b0;
      cal_ff <= 1'b0;
      addr_ff <= ADDR_MODE;
      wdata_ff <= RST_OTHER;
      mode_ff <= RST_MODE;
      fpc_ff <= RST_FP_CTRL;
      fpd_ff <= RST_FP_DIV;
      dlo_ff <= RST_DLY_LO;
      dhi_ff <= RST_DLY_HI;
    end else begin
      cs_prev_ff <= cs_sync;
      we_ff <= nxt_we;
      re_ff <= nxt_re;
      re_d1_ff <= re_ff;
      clr_ff <= hold_rst;
      cal_ff <= nxt_cal;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      mode_ff <= nxt_mode;
      fpc_ff <= nxt_fpc;
      fpd_ff <= nxt_fpd;
      dlo_ff <= nxt_dlo;
      dhi_ff <= nxt_dhi;
    end
  end

  assign mport.we = we_ff;
  assign mport.re = re_ff;
  assign mport.clr = clr_ff;
  assign mport.addr = addr_ff;
  assign mport.wdata = wdata_ff;

  // ***************
  // frame-pulse generator
  // ***************
  pgen_state_t pg_state_ff, nxt_pg_state;
  logic [11:0] half_ff, nxt_half, reload;
  logic [3:0] left_ff, nxt_left, pcount;
  logic phase_ff, nxt_phase, fp_mode, src_repeat, master_ok, burst;

  assign fp_mode = mode_ff[POS_PHASE_SYNC] && fpc_ff[POS_FP_EN] && !mode_ff[POS_POWER_DOWN];
  assign src_repeat = fpc_ff[POS_SRC_SEL];
  assign burst = fpc_ff[POS_BURST];
  assign pcount = fpc_ff[POS_COUNT+3:POS_COUNT];
  assign master_ok = fp_mode && !src_repeat && req_sync;
  // divider field n gives a period of 4 + 2n cycles, half of it high
  assign reload = {1'b0, fpd_ff[DIV_MSB:0]} + 12'h001;

  // burst ends on the falling edge of its last pulse; a new burst
  // needs the request to drop first
  always_comb begin
    nxt_pg_state = pg_state_ff;
    nxt_half = half_ff;
    nxt_left = left_ff;
    nxt_phase = 1'b0;
    case (pg_state_ff)
      PG_IDLE: begin
        if (master_ok && burst && pcount == 4'h0) begin
          nxt_pg_state = PG_DONE;
        end else if (master_ok) begin
          nxt_pg_state = PG_RUN;
          nxt_phase = 1'b1;
          nxt_half = reload;
          nxt_left = pcount;
        end
      end
      PG_RUN: begin
        nxt_phase = phase_ff;
        if (!master_ok) begin
          nxt_pg_state = PG_IDLE;
          nxt_phase = 1'b0;
        end else if (half_ff == 12'h000) begin
          nxt_half = reload;
          nxt_phase = !phase_ff;
          if (phase_ff && burst) begin
            nxt_left = left_ff - 4'h1;
            if (left_ff == 4'h1) begin
              nxt_pg_state = PG_DONE;
            end
          end
        end else begin
          nxt_half = half_ff - 12'h001;
        end
      end
      PG_DONE: begin
        if (!master_ok) begin
          nxt_pg_state = PG_IDLE;
        end
      end
      default: begin
        nxt_pg_state = PG_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pg_state_ff <= PG_IDLE;
      half_ff <= 12'h000;
      left_ff <= 4'h0;
      phase_ff <= 1'b0;
    end else begin
      pg_state_ff <= nxt_pg_state;
      half_ff <= nxt_half;
      left_ff <= nxt_left;
      phase_ff <= nxt_phase;
    end
  end

  // ***************
  // registered outputs
  // ***************
  logic nxt_out;

  // repeater echoes the resampled request; master drives generator phase
  always_comb begin
    if (fp_mode && src_repeat) begin
      nxt_out = req_sync;
    end else begin
      nxt_out = fp_mode && phase_ff;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      SECOND_RF_OUT <= 1'b0;
      LOW_POWER_HOLD <= 1'b0;
      DETERMINISTIC_PHASE_MODE <= 1'b0;
      FRAME_PULSE_MODE <= 1'b0;
      VCO_CAL_TRIGGER <= 1'b0;
      READ_VALID <= 1'b0;
      READ_DATA <= RST_OTHER;
      DELAY_WEIGHT_FIELDS <= 24'h000000;
      INTERPOLATOR_PRESCALER <= 3'h0;
    end else begin
      SECOND_RF_OUT <= nxt_out;
      LOW_POWER_HOLD <= mode_ff[POS_POWER_DOWN];
      DETERMINISTIC_PHASE_MODE <= mode_ff[POS_PHASE_SYNC];
      FRAME_PULSE_MODE <= fp_mode;
      VCO_CAL_TRIGGER <= cal_ff;
      READ_VALID <= re_d1_ff;
      READ_DATA <= re_d1_ff ? mport.rdata : READ_DATA;
      DELAY_WEIGHT_FIELDS <= {dhi_ff[DLY_MSB:0], dlo_ff[DLY_MSB:0]};
      INTERPOLATOR_PRESCALER <= fpc_ff[POS_PRESCALE+2:POS_PRESCALE];
    end
  end

  // ***************
  // checks
  // ***************
  logic [4:0] pulses_ff, nxt_pulses;

  // helper: pulses begun in the current burst
  always_comb begin
    if (pg_state_ff == PG_IDLE) begin
      nxt_pulses = {4'h0, nxt_phase};
    end else begin
      nxt_pulses = pulses_ff + {4'h0, nxt_phase && !phase_ff};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    pulses_ff <= SYS_RST ? 5'h00 : nxt_pulses;
  end

  a_shift_msb: assert property (@(posedge SCK) disable iff (SYS_RST)
    !CS_N |=> shift_ff[0] == $past(SDI)) else $error("serial bit not captured");
  a_write_commit: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    wr |=> we_ff && addr_ff == $past(f_addr) && wdata_ff == $past(f_data))
    else $error("write frame not committed");
  a_read_frame: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    take && shift_ff[RW_POS] |=> re_ff && !we_ff ##2 READ_VALID)
    else $error("read frame mishandled");
  a_short_frame: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    cs_rise && !frame_ok_ff |=> !we_ff && !re_ff) else $error("short frame used");
  a_soft_reset: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    hold_rst |=> clr_ff && mode_ff == RST_MODE && fpc_ff == RST_FP_CTRL)
    else $error("soft reset not applied");
  a_power_down: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    wr && f_addr == ADDR_MODE && f_data[POS_POWER_DOWN]
    |-> ##2 LOW_POWER_HOLD && !FRAME_PULSE_MODE)
    else $error("power-down not entered");
  a_sync_mode: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !mode_ff[POS_PHASE_SYNC] |=> !DETERMINISTIC_PHASE_MODE && !FRAME_PULSE_MODE)
    else $error("mode without phase bit");
  a_repeat_echo: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fp_mode && src_repeat |=> SECOND_RF_OUT == $past(req_sync)) else $error("echo wrong");
  a_burst_count: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(pg_state_ff == PG_DONE) |-> pulses_ff == {1'b0, pcount})
    else $error("burst pulse count wrong");
  a_half_min: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(phase_ff) ##1 master_ok |-> phase_ff) else $error("pulse too short");

endmodule
`default_nettype wire

// [synth_cfg_pkg.sv]
// constants, field layout and reset values of the serial configuration block
// assumes one system clock domain plus the serial clock of the host link
// Operation
// - frame is flag, 7-bit address, 16-bit data
// - flag 0 writes, flag 1 reads
// - capture bits on rising clock, MSB first
// - chip select rise commits data to address
// - reset bit without power-down holds registers reset
// - power-down bit one enters powered-down state
// - deterministic-phase bit one enters sync mode
// - frame pulses need both phase and enable bits
// - repeater mode: request pin toggles make pulses
// - repeater resamples request twice, echoes on output
// - bursts of 1, 2, 4, 8 or continuous
// - pulse rate is output rate over divider; the generator gives a period of 4 + 2n system cycles for divider field n
// - delay weight fields set pulse delay
// - pulse count field 0 to 15, default 4
`default_nettype none
package synth_cfg_pkg;

  // ***************
  // frame layout
  // ***************
  localparam int FRAME_BITS = 24;
  localparam int RW_POS = 23;
  localparam int ADDR_MSB = 22;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam logic [4:0] FRAME_LEN = 5'h18;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam logic [4:0] FIRST_BIT = 5'h00;
  localparam logic RW_WRITE = 1'h0;
  localparam int REG_COUNT = 128;

  // ***************
  // register addresses and fields
  // ***************
  localparam logic [6:0] ADDR_MODE = 7'h00;
  localparam logic [6:0] ADDR_FP_CTRL = 7'h47;
  localparam logic [6:0] ADDR_FP_DIV = 7'h48;
  localparam logic [6:0] ADDR_DLY_LO = 7'h49;
  localparam logic [6:0] ADDR_DLY_HI = 7'h4A;
  localparam int POS_POWER_DOWN = 0;
  localparam int POS_SOFT_RESET = 1;
  localparam int POS_CAL_TRIG = 3;
  localparam int POS_PHASE_SYNC = 14;
  localparam int POS_FP_EN = 0;
  localparam int POS_SRC_SEL = 1;
  localparam int POS_BURST = 2;
  localparam int POS_PRESCALE = 4;
  localparam int POS_COUNT = 8;
  localparam int DIV_MSB = 10;
  localparam int DLY_MSB = 11;

  // ***************
  // reset values
  // ***************
  localparam logic [15:0] RST_MODE = 16'h200C;
  localparam logic [15:0] RST_FP_CTRL = 16'h0410;
  localparam logic [15:0] RST_FP_DIV = 16'h0000;
  localparam logic [15:0] RST_DLY_LO = 16'h06E4;
  localparam logic [15:0] RST_DLY_HI = 16'h0000;
  localparam logic [15:0] RST_OTHER = 16'h0000;

  typedef enum logic [2:0] {
    PG_IDLE = 3'b001,
    PG_RUN = 3'b010,
    PG_DONE = 3'b100
  } pgen_state_t;

  function automatic logic [15:0] reset_word(input logic [6:0] a);
    case (a)
      ADDR_MODE: reset_word = RST_MODE;
      ADDR_FP_CTRL: reset_word = RST_FP_CTRL;
      ADDR_FP_DIV: reset_word = RST_FP_DIV;
      ADDR_DLY_LO: reset_word = RST_DLY_LO;
      ADDR_DLY_HI: reset_word = RST_DLY_HI;
      default: reset_word = RST_OTHER;
    endcase
  endfunction

endpackage
`default_nettype wire

// [mem_port_if.sv]
// port between the frame logic and the register array
// assumes both ends sit on the system clock
`timescale 1ns/1ns
`default_nettype none
interface mem_port_if;
  logic we;
  logic re;
  logic clr;
  logic [6:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctrl (output we, output re, output clr, output addr, output wdata, input rdata);
  modport mem (input we, input re, input clr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [sync_2ff.sv]
// two-stage synchroniser for levels arriving from another domain
// assumes the input changes slowly compared with the clock
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic sync_ff;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// [cfg_reg_mem.sv]
// full register array, including words that only hold stored values
// assumes a single write or read per cycle from the frame logic
`timescale 1ns/1ns
`default_nettype none
module cfg_reg_mem
  import synth_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  mem_port_if.mem port
);
  logic [15:0] mem_ff [0:REG_COUNT-1];
  logic [15:0] rd_ff;
  logic [15:0] nxt_rd;

  // registered read port
  always_comb begin
    nxt_rd = port.re ? mem_ff[port.addr] : rd_ff;
  end

  // clear wins over write; every word returns to its own reset value
  always_ff @(posedge clk) begin
    for (int i = 0; i < REG_COUNT; i++) begin
      if (rst || port.clr) begin
        mem_ff[i] <= reset_word(7'(i));
      end else if (port.we && port.addr == 7'(i)) begin
        mem_ff[i] <= port.wdata;
      end
    end
    rd_ff <= rst ? RST_OTHER : nxt_rd;
  end

  assign port.rdata = rd_ff;
endmodule
`default_nettype wire

// [host_link_model.sv]
// host side of the serial configuration link: frames bits onto the serial pins
// assumes the bench calls frame() only with the chip select idle
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  output logic sck,
  output logic cs_n,
  output logic sdi
);
  // ***************
  // frame driver
  // ***************
  // serial clock stands low outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // send the first nbits of w, flag bit first; fewer than 24 makes a short frame
  task automatic frame(input logic [23:0] w, input int nbits);
    cs_n = 1'b0;
    sdi = w[23];
    #160;
    for (int k = 0; k < nbits; k++) begin
      sdi = w[23 - k];
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    #80 cs_n = 1'b1;
    sdi = ~sdi; // released line must not keep showing the last bit
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench of the serial configuration and frame-pulse block
// assumes host_link_model drives the serial pins and the package constants
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import synth_cfg_pkg::*;
;
  logic CLK_SYS = 1'b0;
  logic SYS_RST = 1'b1;
  logic PULSE_REQUEST_PIN = 1'b0;
  wire logic SCK, CS_N, SDI, SECOND_RF_OUT, LOW_POWER_HOLD, DETERMINISTIC_PHASE_MODE;
  wire logic FRAME_PULSE_MODE, VCO_CAL_TRIGGER, READ_VALID;
  wire logic [15:0] READ_DATA;
  wire logic [23:0] DELAY_WEIGHT_FIELDS;
  wire logic [2:0] INTERPOLATOR_PRESCALER;
  logic [15:0] mem [128];
  logic hist [$];
  logic prev_out = 1'b0;
  int num_errors = 0, total_checks = 0, seed = 89940, cal_n = 0, rises = 0, hi_n = 0, last_hi = 0;
  int rv_n = 0;
  logic [6:0] a;
  logic [15:0] d;
  logic [3:0] cnts [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  logic [15:0] modes [4] = '{16'h0001, 16'h4000, 16'h4001, 16'h4008};

  always #25 CLK_SYS = ~CLK_SYS;

  host_link_model host_u (.sck(SCK), .cs_n(CS_N), .sdi(SDI));

  synth_serial_config_modes dut_u (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SCK(SCK),
    .CS_N(CS_N), .SDI(SDI), .PULSE_REQUEST_PIN(PULSE_REQUEST_PIN),
    .SECOND_RF_OUT(SECOND_RF_OUT), .LOW_POWER_HOLD(LOW_POWER_HOLD),
    .DETERMINISTIC_PHASE_MODE(DETERMINISTIC_PHASE_MODE),
    .FRAME_PULSE_MODE(FRAME_PULSE_MODE), .VCO_CAL_TRIGGER(VCO_CAL_TRIGGER),
    .READ_VALID(READ_VALID), .READ_DATA(READ_DATA),
    .DELAY_WEIGHT_FIELDS(DELAY_WEIGHT_FIELDS), .INTERPOLATOR_PRESCALER(INTERPOLATOR_PRESCALER));

  // ***************
  // monitors and model
  // ***************
  // outputs sampled on the falling edge, where they have settled
  always @(negedge CLK_SYS) begin
    if (VCO_CAL_TRIGGER === 1'b1) cal_n++;
    if (READ_VALID === 1'b1) rv_n++;
    if (SECOND_RF_OUT === 1'b1 && prev_out === 1'b0) begin
      rises++;
      hi_n = 0;
    end
    if (SECOND_RF_OUT === 1'b1) hi_n++;
    if (SECOND_RF_OUT === 1'b0 && prev_out === 1'b1) last_hi = hi_n;
    prev_out = SECOND_RF_OUT;
  end

  task automatic results();
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string name);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // reset image kept apart from the design's own lookup
  task automatic load_defaults();
    foreach (mem[i]) mem[i] = RST_OTHER;
    mem[ADDR_MODE] = RST_MODE;
    mem[ADDR_FP_CTRL] = RST_FP_CTRL;
    mem[ADDR_FP_DIV] = RST_FP_DIV;
    mem[ADDR_DLY_LO] = RST_DLY_LO;
    mem[ADDR_DLY_HI] = RST_DLY_HI;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask

  // write frame; a soft reset write puts every word back to its reset value
  task automatic wr(input logic [6:0] ad, input logic [15:0] dv);
    rv_n = 0;
    host_u.frame({RW_WRITE, ad, dv}, 24);
    idle(12);
    check(24'(rv_n), 24'h000000, "read strobe on write");
    if (ad == ADDR_MODE && dv[1] && !dv[0]) load_defaults();
    else mem[ad] = dv;
  endtask

  task automatic rd(input logic [6:0] ad);
    rv_n = 0;
    host_u.frame({1'b1, ad, 16'h0000}, 24);
    idle(12);
    check(24'(rv_n), 24'h000001, "read strobe");
    check(READ_DATA, mem[ad], "read word");
  endtask

  // ***************
  // main sequence
  // ***************
  initial begin
    load_defaults();
    idle(6);
    SYS_RST = 1'b0;
    idle(4);
    check(DELAY_WEIGHT_FIELDS, 24'h0006E4, "delay weights");
    rd(ADDR_FP_CTRL);
    // power-up order: reset pulse, load from high to low, settle, calibrate
    wr(ADDR_MODE, 16'h0002);
    wr(ADDR_MODE, 16'h2004);
    for (int r = ADDR_DLY_HI; r >= ADDR_FP_CTRL; r--) wr(7'(r), mem[r]);
    // settle wait kept short so the run stays brief
    idle(200);
    cal_n = 0;
    wr(ADDR_MODE, RST_MODE);
    check(24'(cal_n), 24'h000001, "calibration start");
    for (int i = 0; i < 8; i++) begin
      a = (i < 2) ? ADDR_DLY_LO + 7'(i) : 7'($random(seed));
      if (a == ADDR_MODE) a = 7'h7F;
      d = 16'($random(seed));
      wr(a, d);
      rd(a);
    end
    check(DELAY_WEIGHT_FIELDS, {mem[ADDR_DLY_HI][11:0], mem[ADDR_DLY_LO][11:0]},
      "weights");
    check(24'(INTERPOLATOR_PRESCALER), 24'(mem[ADDR_FP_CTRL][6:4]), "prescaler");
    wr(7'h05, 16'hA5C3);
    host_u.frame({RW_WRITE, 7'h05, 16'h1234}, 23);
    idle(12);
    rd(7'h05);
    wr(ADDR_FP_CTRL, 16'h0401);
    foreach (modes[i]) begin
      cal_n = 0;
      wr(ADDR_MODE, modes[i]);
      check(24'(LOW_POWER_HOLD), 24'(modes[i][0]), "power down");
      check(24'(DETERMINISTIC_PHASE_MODE), 24'(modes[i][14]), "phase mode");
      check(24'(FRAME_PULSE_MODE), 24'(modes[i][14] & !modes[i][0]), "pulse mode");
      check(24'(cal_n), 24'(modes[i][3]), "cal pulses");
    end
    wr(ADDR_MODE, 16'h0002);
    rd(7'h05);
    rd(ADDR_MODE);
    check(DELAY_WEIGHT_FIELDS, 24'h0006E4, "weights after soft reset");
    // repeater: output is the request pin three system cycles late
    wr(ADDR_MODE, 16'h4000);
    wr(ADDR_FP_CTRL, 16'h0003);
    repeat (3) hist.push_back(1'b0);
    repeat (100) begin
      @(negedge CLK_SYS);
      check(24'(SECOND_RF_OUT), 24'(hist[$-2]), "repeater echo");
      PULSE_REQUEST_PIN = 1'($random(seed));
      hist.push_back(PULSE_REQUEST_PIN);
    end
    // master bursts: the host holds the request high for the whole burst
    idle(1);
    PULSE_REQUEST_PIN = 1'b0;
    wr(ADDR_FP_DIV, 16'h0001);
    foreach (cnts[i]) begin
      wr(ADDR_FP_CTRL, {4'h0, cnts[i], 8'h05});
      rises = 0;
      last_hi = 0;
      @(negedge CLK_SYS) PULSE_REQUEST_PIN = 1'b1;
      idle(120);
      check(24'(rises), 24'(cnts[i]), "burst pulses");
      if (cnts[i] != 0) check(24'(last_hi), 24'h000003, "pulse high time");
      PULSE_REQUEST_PIN = 1'b0;
    end
    wr(ADDR_FP_CTRL, 16'h0001);
    rises = 0;
    @(negedge CLK_SYS) PULSE_REQUEST_PIN = 1'b1;
    idle(120);
    check(24'(rises >= 19 && rises <= 20), 24'h000001, "continuous pulses");
    results();
  end

  // watchdog, well beyond the length of the sequence above
  initial begin
    #1000000;
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
